// [core/spi_frame_pkg.sv]
package spi_frame_pkg;

  // frame layout
  localparam int ADDR_BITS = 16;
  localparam int CTRL_BITS = 8;
  localparam int HDR_BITS = ADDR_BITS + CTRL_BITS;
  localparam int BYTE_BITS = 8;
  localparam int MAX_BYTES = 4;
  localparam int BLK_POS = 3;
  localparam int RW_POS = 2;

  // length code of the control phase
  localparam logic [1:0] LEN_VAR = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;

  localparam logic RW_READ = 1'h0;
  localparam logic RW_WRITE = 1'h1;

  // low two bits of the block select field pick the block kind
  localparam logic [1:0] KIND_COMMON = 2'h0;
  localparam logic [1:0] KIND_SOCK_REG = 2'h1;
  localparam logic [1:0] KIND_TX_BUF = 2'h2;
  localparam logic [1:0] KIND_RX_BUF = 2'h3;

  // storage sizes
  localparam int SOCKETS = 8;
  localparam int REG_IDX_BITS = 6;
  localparam int REG_SPAN = 64;
  localparam int MEM_BYTES = 16384;
  localparam int SHARE_IDX_BITS = 11;

  // host clock divider: mclk cycles per half period of the link clock
  localparam int HALF_DIV = 4;
  localparam int CMD_DEPTH = 16;

  // data bytes carried for a length code; zero means open-ended
  function automatic logic [2:0] len_bytes(input logic [1:0] code);
    unique case (code)
      LEN_ONE: len_bytes = 3'h1;
      LEN_TWO: len_bytes = 3'h2;
      LEN_FOUR: len_bytes = 3'h4;
      default: len_bytes = 3'h0;
    endcase
  endfunction : len_bytes

  // whether a block and offset hit real storage
  function automatic logic blk_ok(input logic [4:0] blk, input logic [15:0] off);
    logic in_reg;
    in_reg = (off >> REG_IDX_BITS) == 16'h0000;
    unique case (blk[1:0])
      KIND_COMMON: blk_ok = in_reg && (blk[4:2] == 3'h0);
      KIND_SOCK_REG: blk_ok = in_reg;
      default: blk_ok = 1'b1;
    endcase
  endfunction : blk_ok

endpackage : spi_frame_pkg

// [core/spi_link_if.sv]
interface spi_link_if;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // the line reads low while nobody drives it
  assign miso = miso_oe & miso_out;

  modport device (
    input sclk,
    input chip_select_n,
    input mosi,
    output miso_out,
    output miso_oe
  );

  modport host (
    output sclk,
    output chip_select_n,
    output mosi,
    input miso
  );
endinterface : spi_link_if

// [core/cmd_fifo.sv]
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  // depth must be a power of two: pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_s;

  fifo_s f;
  fifo_s next_f;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // honest flags from the pointers
  assign empty = f.wr == f.rd;
  assign full = (f.wr[AW] != f.rd[AW]) && (f.wr[AW-1:0] == f.rd[AW-1:0]);
  assign push = in_valid_i && !full;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[f.rd[AW-1:0]];

  always_comb begin
    next_f = f;
    if (push) begin
      next_f.wr = f.wr + 1'b1;
    end
    if (pop) begin
      next_f.rd = f.rd + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // storage needs no reset, the pointers guard it
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[f.wr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : cmd_fifo

// [core/spi_frame_device.sv]
module spi_frame_device (
  spi_link_if.device link,
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic fixed_length_mode_i,
  output logic wr_valid_o,
  output logic [4:0] wr_block_o,
  output logic [15:0] wr_offset_o,
  output logic [7:0] wr_data_o
);
  localparam int RB = spi_frame_pkg::REG_IDX_BITS;
  localparam int SB = spi_frame_pkg::SHARE_IDX_BITS;
  localparam int SPAN = spi_frame_pkg::REG_SPAN;
  localparam int NSOCK = spi_frame_pkg::SOCKETS;
  localparam int MEMB = spi_frame_pkg::MEM_BYTES;
  localparam logic [4:0] LAST_ADDR = 5'(spi_frame_pkg::ADDR_BITS - 1);
  localparam logic [4:0] LAST_CTRL = 5'(spi_frame_pkg::CTRL_BITS - 1);
  localparam logic [4:0] LAST_DATA = 5'(spi_frame_pkg::BYTE_BITS - 1);

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CTRL = 2'b01,
    PH_DATA = 2'b10
  } phase_e;

  // link clock domain, cleared by deselect or reset
  typedef struct packed {
    phase_e phase;
    logic [4:0] bit_cnt;
    logic [15:0] offset;
    logic [7:0] ctrl;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [2:0] byte_cnt;
    logic mode_s1;
    logic mode_s2;
  } link_s;

  // link clock domain, survives deselect so the toggle stays honest
  typedef struct packed {
    logic tgl;
    logic [4:0] blk;
    logic [15:0] off;
    logic [7:0] data;
  } evt_s;

  // system clock domain
  typedef struct packed {
    logic rst_hold;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic wr_valid;
    logic [4:0] blk;
    logic [15:0] off;
    logic [7:0] data;
  } user_s;

  localparam user_s USER_RESET = '{rst_hold: 1'b1, default: '0};

  link_s ls;
  link_s next_ls;
  evt_s ev;
  evt_s next_ev;
  user_s um;
  user_s next_um;

  // storage of every block
  logic [7:0] common_mem [SPAN];
  logic [7:0] sock_mem [NSOCK * SPAN];
  logic [7:0] tx_mem [MEMB];
  logic [7:0] rx_mem [MEMB];

  logic frame_clr;
  logic we;
  logic [4:0] w_blk;
  logic [15:0] w_off;
  logic [7:0] w_data;
  logic [4:0] r_blk;
  logic [15:0] r_off;
  logic [7:0] r_data;
  logic [2:0] frame_len;
  logic byte_done;

  // in variable mode a frame ends with its own deselect; reset reaches the link side too
  assign frame_clr = link.chip_select_n | um.rst_hold;

  // drive read bytes after the control phase
  assign link.miso_out = ls.tx[7];
  assign link.miso_oe = (ls.phase == PH_DATA) && (ls.ctrl[spi_frame_pkg::RW_POS] == spi_frame_pkg::RW_READ);

  // read port: the first byte uses the control bits still arriving
  assign r_blk = (ls.phase == PH_CTRL) ? ls.ctrl[6:2] : ls.ctrl[7:3];
  assign r_off = (ls.phase == PH_CTRL) ? ls.offset : ls.offset + 16'h0001;

  // length code picks the data length
  assign frame_len = spi_frame_pkg::len_bytes(ls.ctrl[1:0]);
  assign byte_done = (ls.phase == PH_DATA) && (ls.bit_cnt == LAST_DATA);

  // block select field steers the read
  always_comb begin
    r_data = 8'h00;
    if (spi_frame_pkg::blk_ok(r_blk, r_off)) begin
      unique case (r_blk[1:0])
        spi_frame_pkg::KIND_COMMON: r_data = common_mem[r_off[RB-1:0]];
        spi_frame_pkg::KIND_SOCK_REG: r_data = sock_mem[{r_blk[4:2], r_off[RB-1:0]}];
        spi_frame_pkg::KIND_TX_BUF: r_data = tx_mem[{r_blk[4:2], r_off[SB-1:0]}];
        spi_frame_pkg::KIND_RX_BUF: r_data = rx_mem[{r_blk[4:2], r_off[SB-1:0]}];
      endcase
    end
  end

  // frame sequencer, one mosi bit per rising edge
  always_comb begin
    next_ls = ls;
    next_ev = ev;
    we = 1'b0;
    w_blk = ls.ctrl[7:3];
    w_off = ls.offset;
    w_data = {ls.rx[6:0], link.mosi};
    next_ls.mode_s1 = fixed_length_mode_i;
    next_ls.mode_s2 = ls.mode_s1;
    next_ls.bit_cnt = ls.bit_cnt + 5'h01;
    unique case (ls.phase)
      PH_ADDR: begin
        // offset arrives most significant bit first
        next_ls.offset = {ls.offset[14:0], link.mosi};
        if (ls.bit_cnt == LAST_ADDR) begin
          next_ls.phase = PH_CTRL;
          next_ls.bit_cnt = 5'h00;
        end
      end
      PH_CTRL: begin
        next_ls.ctrl = {ls.ctrl[6:0], link.mosi};
        if (ls.bit_cnt == LAST_CTRL) begin
          next_ls.phase = PH_DATA;
          next_ls.bit_cnt = 5'h00;
          next_ls.byte_cnt = 3'h0;
          next_ls.tx = r_data;
        end
      end
      PH_DATA: begin
        next_ls.rx = {ls.rx[6:0], link.mosi};
        next_ls.tx = {ls.tx[6:0], 1'b0};
        if (byte_done) begin
          next_ls.bit_cnt = 5'h00;
          next_ls.byte_cnt = ls.byte_cnt + 3'h1;
          // each byte moves to the next offset
          next_ls.offset = ls.offset + 16'h0001;
          if (ls.ctrl[spi_frame_pkg::RW_POS] == spi_frame_pkg::RW_WRITE) begin
            // captured write byte stored and reported
            we = 1'b1;
            next_ev.tgl = ~ev.tgl;
            next_ev.blk = w_blk;
            next_ev.off = w_off;
            next_ev.data = w_data;
          end else begin
            next_ls.tx = r_data;
          end
          // fixed-length mode ends frames by count
          // stop after exactly the coded bytes
          // next bit starts a new address phase
          if (ls.mode_s2 && (frame_len != 3'h0) && (ls.byte_cnt + 3'h1 == frame_len)) begin
            next_ls.phase = PH_ADDR;
          end
        end
      end
      default: begin
        next_ls.phase = PH_ADDR;
        next_ls.bit_cnt = 5'h00;
      end
    endcase
  end

  always_ff @(posedge link.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      ls <= '0;
    end else begin
      ls <= next_ls;
    end
  end

  always_ff @(posedge link.sclk or posedge um.rst_hold) begin
    if (um.rst_hold) begin
      ev <= '0;
    end else begin
      ev <= next_ev;
    end
  end

  // one common, eight socket register and buffer blocks
  // block select field steers the write
  // transmit shares wrap in one 16KB memory
  // receive shares wrap in one 16KB memory
  // any offset accepted, folded into the share
  always_ff @(posedge link.sclk) begin
    if (we && spi_frame_pkg::blk_ok(w_blk, w_off)) begin
      unique case (w_blk[1:0])
        spi_frame_pkg::KIND_COMMON: common_mem[w_off[RB-1:0]] <= w_data;
        spi_frame_pkg::KIND_SOCK_REG: sock_mem[{w_blk[4:2], w_off[RB-1:0]}] <= w_data;
        spi_frame_pkg::KIND_TX_BUF: tx_mem[{w_blk[4:2], w_off[SB-1:0]}] <= w_data;
        spi_frame_pkg::KIND_RX_BUF: rx_mem[{w_blk[4:2], w_off[SB-1:0]}] <= w_data;
      endcase
    end
  end

  // toggle crossing into the system clock; the word is stable
  // for a whole byte time, far longer than the synchroniser
  always_comb begin
    next_um = um;
    next_um.rst_hold = 1'b0;
    next_um.tgl_s1 = ev.tgl;
    next_um.tgl_s2 = um.tgl_s1;
    next_um.tgl_s3 = um.tgl_s2;
    next_um.wr_valid = um.tgl_s2 ^ um.tgl_s3;
    if (um.tgl_s2 ^ um.tgl_s3) begin
      next_um.blk = ev.blk;
      next_um.off = ev.off;
      next_um.data = ev.data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      um <= USER_RESET;
    end else begin
      um <= next_um;
    end
  end

  assign wr_valid_o = um.wr_valid;
  assign wr_block_o = um.blk;
  assign wr_offset_o = um.off;
  assign wr_data_o = um.data;
endmodule : spi_frame_device

// [core/spi_frame_host.sv]
module spi_frame_host #(
  parameter int HALF_DIV = spi_frame_pkg::HALF_DIV,
  parameter int FIFO_DEPTH = spi_frame_pkg::CMD_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic fixed_length_mode_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic [4:0] cmd_block_i,
  input wire logic [15:0] cmd_offset_i,
  input wire logic [1:0] cmd_len_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic busy_o,
  spi_link_if.host link
);
  localparam int CMD_W = 56;
  localparam int FRAME_W = spi_frame_pkg::HDR_BITS + 32;
  localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
  localparam logic [5:0] HDR = 6'(spi_frame_pkg::HDR_BITS);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW = 2'b01,
    H_HIGH = 2'b10,
    H_GAP = 2'b11
  } host_e;

  typedef struct packed {
    host_e state;
    logic [7:0] div;
    logic [5:0] bit_cnt;
    logic [5:0] total;
    logic [FRAME_W-1:0] shift;
    logic [31:0] rx;
    logic write;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_s1;
    logic miso_s2;
    logic rd_valid;
    logic [31:0] rd_data;
  } host_s;

  localparam host_s HOST_RESET = '{state: H_IDLE, cs_n: 1'b1, default: '0};

  host_s h;
  host_s next_h;
  logic f_valid;
  logic f_pop;
  logic [CMD_W-1:0] f_data;
  logic [2:0] nbytes;
  logic [1:0] code;
  logic [31:0] aligned;

  // commands wait here; popping stalls while a frame runs
  cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .in_data_i({cmd_write_i, cmd_block_i, cmd_offset_i, cmd_len_i, cmd_wdata_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  assign f_pop = h.state == H_IDLE;
  // 1/2/4 byte lengths are sent; length code 0 sends the header alone
  assign nbytes = spi_frame_pkg::len_bytes(f_data[33:32]);
  // length code sent only in fixed-length mode
  assign code = fixed_length_mode_i ? f_data[33:32] : spi_frame_pkg::LEN_VAR;
  // first data byte leads on the wire
  assign aligned = f_data[31:0] << {3'(spi_frame_pkg::MAX_BYTES) - nbytes, 3'b000};

  always_comb begin
    next_h = h;
    next_h.rd_valid = 1'b0;
    next_h.miso_s1 = link.miso;
    next_h.miso_s2 = h.miso_s1;
    next_h.div = h.div + 8'h01;
    unique case (h.state)
      H_IDLE: begin
        // chip select held low in fixed-length mode
        next_h.cs_n = !fixed_length_mode_i;
        next_h.div = 8'h00;
        if (f_valid) begin
          // write flag 1; read flag 0
          next_h.shift = {f_data[49:34], f_data[54:50], f_data[55], code, aligned};
          next_h.write = f_data[55];
          next_h.total = HDR + {nbytes, 3'b000};
          next_h.bit_cnt = 6'h00;
          next_h.rx = 32'h0000_0000;
          next_h.mosi = f_data[49];
          next_h.cs_n = 1'b0;
          next_h.state = H_LOW;
        end
      end
      H_LOW: begin
        if (h.div == DIV_LAST) begin
          // sample returned data on the rise
          next_h.sclk = 1'b1;
          next_h.div = 8'h00;
          if (h.bit_cnt >= HDR) begin
            next_h.rx = {h.rx[30:0], h.miso_s2};
          end
          next_h.state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (h.div == DIV_LAST) begin
          // next bit shifted out on the fall
          next_h.sclk = 1'b0;
          next_h.div = 8'h00;
          next_h.bit_cnt = h.bit_cnt + 6'h01;
          if (h.bit_cnt == h.total - 6'h01) begin
            // variable mode ends the frame by deselect
            next_h.cs_n = !fixed_length_mode_i;
            next_h.rd_valid = !h.write;
            next_h.rd_data = h.rx;
            next_h.state = H_GAP;
          end else begin
            next_h.shift = {h.shift[FRAME_W-2:0], 1'b0};
            next_h.mosi = h.shift[FRAME_W-2];
            next_h.state = H_LOW;
          end
        end
      end
      H_GAP: begin
        if (h.div == DIV_LAST) begin
          next_h.state = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      h <= HOST_RESET;
    end else begin
      h <= next_h;
    end
  end

  assign link.sclk = h.sclk;
  assign link.chip_select_n = h.cs_n;
  assign link.mosi = h.mosi;
  assign rd_valid_o = h.rd_valid;
  assign rd_data_o = h.rd_data;
  assign busy_o = h.state != H_IDLE;
endmodule : spi_frame_host

// [verification/spi_link_props.sv]
module spi_link_props (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_q;
  logic [15:0] rise_cnt;
  logic [7:0] oe_cnt;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // link clock rises counted per select and per read data stretch
  always_ff @(posedge mclk_i) begin
    sclk_q <= sclk;
    if (!rstn_i || chip_select_n) begin
      rise_cnt <= 16'h0000;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 16'h0001;
    end
    if (!rstn_i || !miso_oe) begin
      oe_cnt <= 8'h00;
    end else if (sclk && !sclk_q) begin
      oe_cnt <= oe_cnt + 8'h01;
    end
  end

  // one link bit is four system clocks high, then four low
  sequence seq_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence seq_low;
    !sclk [*4];
  endsequence

  chk_sclk_high_width: assert property ($rose(sclk) |-> seq_high)
    else $error("link clock high phase has wrong length");
  chk_sclk_low_width: assert property ($fell(sclk) |-> seq_low)
    else $error("link clock low phase too short");
  chk_mosi_on_low: assert property ($changed(mosi) |-> !sclk)
    else $error("host data moved while link clock high");
  chk_sclk_idle_desel: assert property (chip_select_n |-> !sclk)
    else $error("link clock toggles outside a frame");
  chk_miso_needs_select: assert property (miso_oe |-> !chip_select_n)
    else $error("device drives data line while deselected");
  chk_miso_start_edge: assert property ($rose(miso_oe) |-> $rose(sclk))
    else $error("read data not launched after a link clock rise");
  // a select window carries header plus one, two or four bytes
  chk_frame_bit_count: assert property ($rose(chip_select_n) |-> rise_cnt inside {16'd32, 16'd40, 16'd56})
    else $error("frame bit count is not header plus 1, 2 or 4 bytes");
  // the read stretch covers the last header bit plus the data bits
  chk_read_byte_count: assert property ($fell(miso_oe) |-> oe_cnt inside {[8:9], [16:17], [32:33]})
    else $error("read data stretch has wrong length");
  chk_select_gap: assert property ($rose(chip_select_n) |-> chip_select_n [*4])
    else $error("deselect gap too short");
  // read data may only move in the step of a link clock rise, so the host sees a whole bit
  chk_miso_hold_bit: assert property (miso_oe && $changed(miso_out) |-> $rose(sclk))
    else $error("read data bit moved between link clock rises");
  // a released data line falls back to its pull-down level
  chk_miso_release_low: assert property ($fell(miso_oe) |-> !miso)
    else $error("data line not low after release");
endmodule : spi_link_props

// [verification/spi_fixed_length_frame_access_tb.sv]
module spi_fixed_length_frame_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic fixed_mode = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [4:0] cmd_block = 5'h00;
  logic [15:0] cmd_offset = 16'h0000;
  logic [1:0] cmd_len = 2'h1;
  logic [31:0] cmd_wdata = 32'h00000000;
  logic cmd_ready;
  logic rd_valid;
  logic busy;
  logic wr_valid;
  logic [31:0] rd_data;
  logic [4:0] wr_block;
  logic [15:0] wr_offset;
  logic [7:0] wr_data;
  logic [28:0] wrq[$];
  logic [31:0] rdq[$];
  int n_mismatch = 0;
  int n_tests = 0;

  always #12.5 mclk_i = ~mclk_i;

  spi_link_if link ();
  spi_frame_host u_spi_frame_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .fixed_length_mode_i(fixed_mode),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write), .cmd_block_i(cmd_block),
    .cmd_offset_i(cmd_offset), .cmd_len_i(cmd_len), .cmd_wdata_i(cmd_wdata), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .busy_o(busy), .link(link));
  spi_frame_device u_spi_frame_device (.link(link), .mclk_i(mclk_i), .rstn_i(rstn_i),
    .fixed_length_mode_i(fixed_mode), .wr_valid_o(wr_valid), .wr_block_o(wr_block),
    .wr_offset_o(wr_offset), .wr_data_o(wr_data));
  spi_link_props u_spi_link_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .sclk(link.sclk),
    .chip_select_n(link.chip_select_n), .mosi(link.mosi), .miso_out(link.miso_out),
    .miso_oe(link.miso_oe), .miso(link.miso));

  // collect every byte write and read completion for later comparison
  always @(posedge mclk_i) begin
    if (wr_valid === 1'b1) wrq.push_back({wr_block, wr_offset, wr_data});
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic bad(input string msg);
    n_mismatch++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  function automatic int nb(input logic [1:0] l);
    return (l == 2'h3) ? 4 : int'(l);
  endfunction : nb

  // mode is only changed under reset, when the host queue is surely empty
  task automatic do_reset(input logic mode);
    rstn_i = 1'b0;
    fixed_mode = mode;
    repeat (3) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    wrq.delete();
    rdq.delete();
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : do_reset

  task automatic push(input logic w, input logic [4:0] b, input logic [15:0] o, input logic [1:0] l,
                      input logic [31:0] d);
    int k;
    k = 0;
    {cmd_write, cmd_block, cmd_offset, cmd_len, cmd_wdata} = {w, b, o, l, d};
    cmd_valid = 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
    end while (cmd_ready !== 1'b1 && k < 100);
    // a command never taken counts against the run
    if (cmd_ready !== 1'b1) bad("command not taken");
    #1 cmd_valid = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask : push

  task automatic wait_for(input int nw, input int nr);
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while ((wrq.size() < nw || rdq.size() < nr) && k < 3000);
    #1;
    if (k >= 3000) bad("no completion");
  endtask : wait_for

  task automatic check_wr(input logic [4:0] b, input logic [15:0] o, input logic [7:0] d);
    logic [28:0] got;
    n_tests++;
    got = (wrq.size() > 0) ? wrq.pop_front() : 29'h0;
    if (got !== {b, o, d}) bad("byte write differs");
  endtask : check_wr

  task automatic check_rd(input logic [31:0] e);
    logic [31:0] got;
    n_tests++;
    got = (rdq.size() > 0) ? rdq.pop_front() : 32'hDEADBEEF;
    if (got !== e) bad("read data differs");
  endtask : check_rd

  // host must be back to idle once its queue has drained
  task automatic check_idle;
    n_tests++;
    if (busy !== 1'b0) bad("host still busy after last frame");
  endtask : check_idle

  task automatic exp_wr(input logic [4:0] b, input logic [15:0] o, input logic [1:0] l, input logic [31:0] d);
    for (int k = 0; k < nb(l); k++) begin
      check_wr(b, o + 16'(k), d[8 * (nb(l) - 1 - k) +: 8]);
    end
  endtask : exp_wr

  task automatic wr_rd(input logic [4:0] b, input logic [15:0] o, input logic [1:0] l, input logic [31:0] d);
    push(1'b1, b, o, l, d);
    wait_for(nb(l), 0);
    exp_wr(b, o, l, d);
    push(1'b0, b, o, l, 32'h0);
    wait_for(0, 1);
    check_rd(d);
    // gap of four clocks after the read pulse, then idle
    repeat (4) @(posedge mclk_i);
    #1;
    check_idle();
  endtask : wr_rd

  initial begin
    do_reset(1'b1);
    // four bytes each way with select held low
    wr_rd(5'h06, 16'h0040, 2'h3, 32'h11223344);
    $display("test four_byte done");
    // back to back frames of length codes 1, 2 and 3, no deselect between them
    push(1'b1, 5'h00, 16'h0010, 2'h1, 32'h000000AA);
    push(1'b1, 5'h1D, 16'h003E, 2'h2, 32'h0000BBCC);
    push(1'b1, 5'h0F, 16'hFFFC, 2'h3, 32'h55667788);
    wait_for(7, 0);
    exp_wr(5'h00, 16'h0010, 2'h1, 32'h000000AA);
    exp_wr(5'h1D, 16'h003E, 2'h2, 32'h0000BBCC);
    exp_wr(5'h0F, 16'hFFFC, 2'h3, 32'h55667788);
    push(1'b0, 5'h00, 16'h0010, 2'h1, 32'h0);
    push(1'b0, 5'h1D, 16'h003E, 2'h2, 32'h0);
    push(1'b0, 5'h0F, 16'h07FC, 2'h3, 32'h0);
    wait_for(0, 3);
    check_rd(32'h000000AA);
    check_rd(32'h0000BBCC);
    check_rd(32'h55667788);
    $display("test length_codes done");
    // places outside real storage read back as zero
    push(1'b0, 5'h04, 16'h0010, 2'h1, 32'h0);
    push(1'b0, 5'h01, 16'h0040, 2'h1, 32'h0);
    wait_for(0, 2);
    check_rd(32'h00000000);
    check_rd(32'h00000000);
    $display("test unmapped done");
    // reset in mid-run, then frames bounded by the select line
    do_reset(1'b0);
    wr_rd(5'h0A, 16'h1234, 2'h2, 32'h0000A55A);
    wr_rd(5'h0E, 16'h8000, 2'h3, 32'hC3A50F96);
    $display("test variable_mode done");
    close_out();
  end

  // hang guard, far beyond the fourteen frames above
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad("watchdog expired");
    close_out();
  end
endmodule : spi_fixed_length_frame_access_tb
